// ### common/pse_pkg.sv
/*
  Shared constants for the PTP slave time counter and event messages:
  register map, field positions, timing counts, PTP message codes and the
  sync state type. Assumes a 10 MHz system clock and a 32-bit APB slave.
*/
package pse_pkg;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TIME_LO = 8'h0c;
  localparam logic [7:0] REG_TIME_HI = 8'h10;
  localparam logic [7:0] REG_CAP_LO = 8'h14;
  localparam logic [7:0] REG_CAP_HI = 8'h18;
  localparam logic [7:0] REG_FREQ_LO = 8'h1c;
  localparam logic [7:0] REG_FREQ_HI = 8'h20;
  localparam logic [7:0] REG_EVT_SEL = 8'h24;
  localparam logic [7:0] REG_EVT_NOTIFY = 8'h28;
  localparam logic [7:0] REG_ACQ_TIME_LO = 8'h2c;
  localparam logic [7:0] REG_ACQ_TIME_HI = 8'h30;
  localparam logic [7:0] REG_ACQ_FRAME = 8'h34;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_CAPTURE_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b0;
  localparam logic [1:0] NOTIFY_RESET = 2'h0;
  localparam logic EVT_SEL_RESET = 1'b0;

  // ==========================================================
  // Timing
  localparam logic [63:0] TICK_FREQ = 64'h000000003b9aca00;
  localparam logic [63:0] SYS_CLK_FREQ = 64'h0000000000989680;
  localparam logic [63:0] TICK_STEP = TICK_FREQ / SYS_CLK_FREQ;
  localparam logic [63:0] TIME_MAX = 64'h7fffffffffffffff;

  // ==========================================================
  // PTP transport
  localparam logic [31:0] PTP_GROUP_IP = 32'he0000181;
  localparam logic [15:0] PORT_EVENT = 16'h013f;
  localparam logic [15:0] PORT_GENERAL = 16'h0140;
  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
  localparam logic [3:0] MSG_PDELAY_REQ = 4'h2;
  localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;
  localparam logic [3:0] MSG_FOLLOW_UP = 4'h8;
  localparam logic [3:0] MSG_DELAY_RESP = 4'h9;
  localparam logic [3:0] MSG_ANNOUNCE = 4'hb;

  // ==========================================================
  // Events; the frame start identifier is arbitrary
  localparam int EVT_COUNT = 2;
  localparam int EVT_ACQ_START = 0;
  localparam int EVT_FRAME_START = 1;
  localparam logic [15:0] EVT_ID_ACQ_START = 16'h9011;
  localparam logic [15:0] EVT_ID_FRAME_START = 16'h9012;

  typedef enum logic [1:0] {
    PSE_DISABLED,
    PSE_LISTENING,
    PSE_UNCALIBRATED,
    PSE_SLAVE
  } pse_state_t;

  // ==========================================================
  // Destination port for a message type
  function automatic logic [15:0] portFor(input logic [3:0] msgType);
    if (msgType[3] == 1'b0) begin
      portFor = PORT_EVENT;
    end else begin
      portFor = PORT_GENERAL;
    end
  endfunction

  function automatic logic addrHit(input logic [7:0] addr);
    addrHit = (addr[1:0] == 2'h0) && (addr <= REG_ACQ_FRAME);
  endfunction

endpackage

// ### rtl/pse_event_msg.sv
/*
  Event message builder: captures time and frame number when an enabled
  event occurs and hands one message at a time to the host side.
  Assumes event pulses and the receiver's ready come from the same clock.
*/
module pse_event_msg (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] evtPulse,
  input wire logic [1:0] notifyEn,
  input wire logic [63:0] timeNow,
  input wire logic [31:0] frameNow,
  output logic evtValid,
  input wire logic evtReady,
  output logic [15:0] evtId,
  output logic [63:0] evtTime,
  output logic [31:0] evtFrame,
  output logic [63:0] acqTime,
  output logic [31:0] acqFrame
);

  logic [1:0] pend_reg;
  logic [63:0] capTime_reg [2];
  logic [31:0] capFrame_reg [2];
  logic [1:0] fire;
  logic [1:0] take;
  logic slotFree;

  // ==========================================================
  // Capture and pending
  assign fire = evtPulse & notifyEn;
  assign slotFree = !evtValid || evtReady;
  assign take = !slotFree ? 2'h0 : pend_reg[0] ? 2'h1 : pend_reg[1] ? 2'h2 : 2'h0;

  // A new event in the cycle its old copy leaves stays pending
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 2'h0;
    end else begin
      pend_reg <= (pend_reg & ~take) | fire;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      capTime_reg[0] <= 64'h0;
      capTime_reg[1] <= 64'h0;
      capFrame_reg[0] <= 32'h0;
      capFrame_reg[1] <= 32'h0;
    end else begin
      for (int i = 0; i < pse_pkg::EVT_COUNT; i++) begin
        if (fire[i]) begin
          capTime_reg[i] <= timeNow;
          capFrame_reg[i] <= frameNow;
        end
      end
    end
  end

  // ==========================================================
  // Output message
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      evtValid <= 1'b0;
      evtId <= 16'h0;
      evtTime <= 64'h0;
      evtFrame <= 32'h0;
    end else if (take[0]) begin
      evtValid <= 1'b1;
      evtId <= pse_pkg::EVT_ID_ACQ_START;
      evtTime <= capTime_reg[0];
      evtFrame <= capFrame_reg[0];
    end else if (take[1]) begin
      evtValid <= 1'b1;
      evtId <= pse_pkg::EVT_ID_FRAME_START;
      evtTime <= capTime_reg[1];
      evtFrame <= capFrame_reg[1];
    end else if (evtReady) begin
      evtValid <= 1'b0;
    end
  end

  assign acqTime = capTime_reg[0];
  assign acqFrame = capFrame_reg[0];

  // ==========================================================
  // Checks
  chk_notify_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!notifyEn[0] && !pend_reg[0] && !evtValid) |=> !(evtValid && evtId == 16'h9011))
    else $error("acq start message sent with notification off");
  chk_msg_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (evtValid && !evtReady) |=> (evtValid && $stable(evtId) && $stable(evtTime)))
    else $error("event message dropped before accepted");
  chk_evt_capture: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fire[0] && !pend_reg[0] && slotFree && !pend_reg[1]) |=> ##1
      (evtValid && evtTime == $past(timeNow, 2) && evtFrame == $past(frameNow, 2)))
    else $error("event message time or frame not captured at event");

endmodule

// ### rtl/pse_time_slave.sv
/*
  PTP time-only slave with 63-bit nanosecond time counter, clear and
  capture commands, scheduled actions and event messages, behind APB.
  Assumes received PTP messages arrive already parsed from a MAC on the
  same clock, and that the host drains event messages via evtReady.
*/
// Operation
// - Act only as time slave, never master
// - Multicast group 224.0.1.129; delay response unicast
// - Event messages use UDP port 319
// - General messages use UDP port 320
// - Correct time value only, never rate
// - PTP time is 80-bit nanoseconds since 1970
// - Timestamp equals low 64 bits when synchronized; follow-up load takes low 63 bits, sign bit forced zero
// - Receive announce/sync/follow-up/delay-resp; send delay request
// - Tick frequency reads constant one gigahertz
// - Clear ignored while synchronized
// - Sign bit stays zero, 63 time bits
// - Enable steps states; sync reached shows slave
// - Scheduled actions accepted only while enabled
// - Enabled event sends id, time, frame message
// - Acquisition start event id is 0x9011
// - Message time captured at event moment
// - Message frame captured at event moment
// - Counter wraps to zero past signed maximum
// - Clear command forces counter to zero
// - Capture command copies counter to readable register
module pse_time_slave (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxValid,
  input wire logic [3:0] rxType,
  input wire logic [31:0] rxDstIp,
  input wire logic [15:0] rxDstPort,
  input wire logic [79:0] rxTime,
  output logic txValid,
  output logic [3:0] txType,
  output logic [31:0] txDstIp,
  output logic [15:0] txDstPort,
  output logic [63:0] txTime,
  input wire logic actValid,
  input wire logic [63:0] actTime,
  output logic actFire,
  input wire logic acqStartPulse,
  input wire logic frameStartPulse,
  input wire logic [31:0] frameNumber,
  output logic evtValid,
  input wire logic evtReady,
  output logic [15:0] evtId,
  output logic [63:0] evtTime,
  output logic [31:0] evtFrame
);

  logic ptpEnable_reg;
  logic eventChoice_reg;
  logic [1:0] eventNotify_reg;
  pse_pkg::pse_state_t syncState_reg;
  logic [63:0] timeCount_reg;
  logic [63:0] capturedTime_reg;
  logic actPend_reg;
  logic [63:0] actTime_reg;
  logic [31:0] rdData;
  logic [63:0] acqTime;
  logic [31:0] acqFrame;
  logic apbWrite;
  logic apbSetupRead;
  logic clearReq;
  logic captureReq;
  logic rxAddrOk;
  logic rxAccept;
  logic rxLoad;
  logic clearDo;
  logic [63:0] incSum;
  logic wrapNow;

  // ==========================================================
  // APB access
  assign pready = 1'b1;
  assign apbWrite = psel && penable && pwrite;
  assign apbSetupRead = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !pse_pkg::addrHit(paddr);
  assign clearReq = apbWrite && (paddr == pse_pkg::REG_CMD) &&
                    pwdata[pse_pkg::CMD_CLEAR_BIT];
  assign captureReq = apbWrite && (paddr == pse_pkg::REG_CMD) &&
                      pwdata[pse_pkg::CMD_CAPTURE_BIT];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ptpEnable_reg <= pse_pkg::CTRL_EN_RESET;
      eventChoice_reg <= pse_pkg::EVT_SEL_RESET;
      eventNotify_reg <= pse_pkg::NOTIFY_RESET;
    end else if (apbWrite) begin
      if (paddr == pse_pkg::REG_CTRL) begin
        ptpEnable_reg <= pwdata[pse_pkg::CTRL_EN_BIT];
      end else if (paddr == pse_pkg::REG_EVT_SEL) begin
        eventChoice_reg <= pwdata[0];
      end else if (paddr == pse_pkg::REG_EVT_NOTIFY) begin
        eventNotify_reg[eventChoice_reg] <= pwdata[0];
      end
    end
  end

  // Halves are read separately; capture first for a coherent 64-bit value
  always_comb begin
    if (paddr == pse_pkg::REG_CTRL) begin
      rdData = {31'h0, ptpEnable_reg};
    end else if (paddr == pse_pkg::REG_STATUS) begin
      rdData = {30'h0, syncState_reg};
    end else if (paddr == pse_pkg::REG_TIME_LO) begin
      rdData = timeCount_reg[31:0];
    end else if (paddr == pse_pkg::REG_TIME_HI) begin
      rdData = timeCount_reg[63:32];
    end else if (paddr == pse_pkg::REG_CAP_LO) begin
      rdData = capturedTime_reg[31:0];
    end else if (paddr == pse_pkg::REG_CAP_HI) begin
      rdData = capturedTime_reg[63:32];
    end else if (paddr == pse_pkg::REG_FREQ_LO) begin
      rdData = pse_pkg::TICK_FREQ[31:0];
    end else if (paddr == pse_pkg::REG_FREQ_HI) begin
      rdData = pse_pkg::TICK_FREQ[63:32];
    end else if (paddr == pse_pkg::REG_EVT_SEL) begin
      rdData = {31'h0, eventChoice_reg};
    end else if (paddr == pse_pkg::REG_EVT_NOTIFY) begin
      rdData = {31'h0, eventNotify_reg[eventChoice_reg]};
    end else if (paddr == pse_pkg::REG_ACQ_TIME_LO) begin
      rdData = acqTime[31:0];
    end else if (paddr == pse_pkg::REG_ACQ_TIME_HI) begin
      rdData = acqTime[63:32];
    end else if (paddr == pse_pkg::REG_ACQ_FRAME) begin
      rdData = acqFrame;
    end else begin
      rdData = 32'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
    end else if (apbSetupRead) begin
      prdata <= rdData;
    end
  end

  // ==========================================================
  // Receive filter
  // Delay response is unicast, so it is the one type not tied to the group
  assign rxAddrOk = (rxType == pse_pkg::MSG_DELAY_RESP) ?
                    (rxDstIp != pse_pkg::PTP_GROUP_IP) :
                    (rxDstIp == pse_pkg::PTP_GROUP_IP);
  assign rxAccept = rxValid && ptpEnable_reg && rxAddrOk &&
                    (rxDstPort == pse_pkg::portFor(rxType)) &&
                    ((rxType == pse_pkg::MSG_SYNC) || (rxType == pse_pkg::MSG_FOLLOW_UP) ||
                     (rxType == pse_pkg::MSG_ANNOUNCE) ||
                     (rxType == pse_pkg::MSG_DELAY_RESP));
  assign rxLoad = rxAccept && (syncState_reg == pse_pkg::PSE_SLAVE) &&
                  (rxType == pse_pkg::MSG_FOLLOW_UP);

  // ==========================================================
  // Sync state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      syncState_reg <= pse_pkg::PSE_DISABLED;
    end else if (!ptpEnable_reg) begin
      syncState_reg <= pse_pkg::PSE_DISABLED;
    end else begin
      case (syncState_reg)
        pse_pkg::PSE_DISABLED: begin
          syncState_reg <= pse_pkg::PSE_LISTENING;
        end
        pse_pkg::PSE_LISTENING: begin
          if (rxAccept && rxType == pse_pkg::MSG_SYNC) begin
            syncState_reg <= pse_pkg::PSE_SLAVE;
          end else if (rxAccept && rxType == pse_pkg::MSG_ANNOUNCE) begin
            syncState_reg <= pse_pkg::PSE_UNCALIBRATED;
          end
        end
        pse_pkg::PSE_UNCALIBRATED: begin
          if (rxAccept && rxType == pse_pkg::MSG_SYNC) begin
            syncState_reg <= pse_pkg::PSE_SLAVE;
          end
        end
        default: begin
          syncState_reg <= pse_pkg::PSE_SLAVE;
        end
      endcase
    end
  end

  // ==========================================================
  // Time counter
  assign clearDo = clearReq && (syncState_reg != pse_pkg::PSE_SLAVE);
  assign incSum = {1'b0, timeCount_reg[62:0]} + pse_pkg::TICK_STEP;
  assign wrapNow = incSum > pse_pkg::TIME_MAX;

  // Only the value is stepped; the increment never changes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      timeCount_reg <= 64'h0;
    end else if (rxLoad) begin
      timeCount_reg <= {1'b0, rxTime[62:0]};
    end else if (clearDo) begin
      timeCount_reg <= 64'h0;
    end else if (wrapNow) begin
      timeCount_reg <= 64'h0;
    end else begin
      timeCount_reg <= incSum;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      capturedTime_reg <= 64'h0;
    end else if (captureReq) begin
      capturedTime_reg <= timeCount_reg;
    end
  end

  // ==========================================================
  // Delay request, sent after each follow-up once slave
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txValid <= 1'b0;
      txType <= pse_pkg::MSG_DELAY_REQ;
      txDstIp <= pse_pkg::PTP_GROUP_IP;
      txDstPort <= pse_pkg::PORT_EVENT;
      txTime <= 64'h0;
    end else begin
      txValid <= rxLoad;
      txType <= pse_pkg::MSG_DELAY_REQ;
      txDstIp <= pse_pkg::PTP_GROUP_IP;
      txDstPort <= pse_pkg::portFor(pse_pkg::MSG_DELAY_REQ);
      if (rxLoad) begin
        txTime <= timeCount_reg;
      end
    end
  end

  // ==========================================================
  // Scheduled action
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      actPend_reg <= 1'b0;
      actTime_reg <= 64'h0;
      actFire <= 1'b0;
    end else begin
      actFire <= ptpEnable_reg && actPend_reg && (timeCount_reg >= actTime_reg);
      if (!ptpEnable_reg) begin
        actPend_reg <= 1'b0;
      end else if (actValid) begin
        actPend_reg <= 1'b1;
        actTime_reg <= actTime;
      end else if (timeCount_reg >= actTime_reg) begin
        actPend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Event messages
  pse_event_msg u_event_msg (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .evtPulse({frameStartPulse, acqStartPulse}),
    .notifyEn(eventNotify_reg),
    .timeNow(timeCount_reg),
    .frameNow(frameNumber),
    .evtValid(evtValid),
    .evtReady(evtReady),
    .evtId(evtId),
    .evtTime(evtTime),
    .evtFrame(evtFrame),
    .acqTime(acqTime),
    .acqFrame(acqFrame)
  );

  // ==========================================================
  // Checks
  chk_sign_bit_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    timeCount_reg[63] == 1'b0)
    else $error("time counter sign bit set");
  chk_free_run: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!rxLoad && !clearDo && !wrapNow) |=>
      timeCount_reg == $past(timeCount_reg) + pse_pkg::TICK_STEP)
    else $error("time counter did not advance by 100 ns");
  chk_clear_blocked: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clearReq && syncState_reg == pse_pkg::PSE_SLAVE && !rxLoad && !wrapNow) |=>
      timeCount_reg == $past(incSum))
    else $error("clear acted while synchronized");
  chk_clear_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clearReq && syncState_reg != pse_pkg::PSE_SLAVE) |=> timeCount_reg == 64'h0)
    else $error("clear did not zero the counter");
  chk_wrap_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wrapNow && !rxLoad) |=> timeCount_reg == 64'h0)
    else $error("counter did not wrap to zero");
  chk_time_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    rxLoad |=> timeCount_reg == {1'b0, $past(rxTime[62:0])})
    else $error("follow-up time not loaded");
  chk_capture_value: assert property (@(posedge sys_clk) disable iff (!resetn)
    captureReq |=> capturedTime_reg == $past(timeCount_reg))
    else $error("capture register wrong");
  chk_sync_to_slave: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ptpEnable_reg && rxAccept && rxType == pse_pkg::MSG_SYNC &&
     syncState_reg != pse_pkg::PSE_DISABLED) ##1 ptpEnable_reg |->
      syncState_reg == pse_pkg::PSE_SLAVE)
    else $error("sync did not reach slave state");
  chk_disable_state: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ptpEnable_reg |=> syncState_reg == pse_pkg::PSE_DISABLED)
    else $error("state not disabled with ptp off");
  chk_tx_delay_req: assert property (@(posedge sys_clk) disable iff (!resetn)
    txValid |-> (txType == 4'h1 && txDstPort == 16'h013f && $past(rxLoad)))
    else $error("transmitted message not a delay request");
  chk_action_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ptpEnable_reg |=> (!actPend_reg && !actFire))
    else $error("action held while ptp disabled");

  cov_reach_slave: cover property (@(posedge sys_clk) disable iff (!resetn)
    syncState_reg == pse_pkg::PSE_UNCALIBRATED ##1 syncState_reg == pse_pkg::PSE_SLAVE);
  cov_clear_blocked: cover property (@(posedge sys_clk) disable iff (!resetn)
    clearReq && syncState_reg == pse_pkg::PSE_SLAVE);
  cov_action_fire: cover property (@(posedge sys_clk) disable iff (!resetn) actFire);
  cov_event_sent: cover property (@(posedge sys_clk) disable iff (!resetn)
    evtValid && evtReady && evtId == 16'h9011);

endmodule

// ### bench/pse_ptp_master.sv
/*
  Behavioural PTP master: hands parsed messages to the slave, one per call.
  Assumes the caller is the bench top and that sys_clk is the design's clock.
*/
module pse_ptp_master (
  input wire logic sys_clk,
  input wire logic txValid,
  output logic rxValid,
  output logic [3:0] rxType,
  output logic [31:0] rxDstIp,
  output logic [15:0] rxDstPort,
  output logic [79:0] rxTime
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Master side message source
  int delayReqs = 0;
  initial begin
    rxValid = 1'b0;
    rxType = 4'h0;
    rxDstIp = 32'h0;
    rxDstPort = 16'h0;
    rxTime = 80'h0;
  end
  always @(posedge sys_clk) if (txValid === 1'b1) delayReqs <= delayReqs + 1;
  // Bad flips the port, to see a misrouted message dropped
  task automatic send(input logic [3:0] t, input logic [79:0] tm, input logic bad);
    @(posedge sys_clk);
    rxValid <= 1'b1;
    rxType <= t;
    rxDstIp <= (t == pse_pkg::MSG_DELAY_RESP) ? 32'h0a000001 : pse_pkg::PTP_GROUP_IP;
    rxDstPort <= (t[3] ^ bad) ? pse_pkg::PORT_GENERAL : pse_pkg::PORT_EVENT;
    rxTime <= tm;
    @(posedge sys_clk);
    rxValid <= 1'b0;
    // Released lines invert, so stale values never look valid
    rxType <= ~t;
    rxDstIp <= ~rxDstIp;
    rxDstPort <= ~rxDstPort;
    rxTime <= ~tm;
  endtask
endmodule

// ### bench/pse_time_slave_tb.sv
/*
  Self-checking bench for the PTP slave time counter over APB.
  Assumes zero-wait APB and a 100 ns clock; counter steps 100 per cycle.
*/
module pse_time_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, actValid = 1'b0, evtReady = 1'b0;
  logic acqStartPulse = 1'b0, frameStartPulse = 1'b0, errBit;
  logic [31:0] pwdata = 32'h0, frameNumber = 32'h0, prdata, rdData, rxDstIp, txDstIp, evtFrame;
  logic pready, pslverr, rxValid, txValid, actFire, evtValid;
  logic [3:0] rxType, txType;
  logic [15:0] rxDstPort, txDstPort, evtId;
  logic [79:0] rxTime;
  logic [63:0] txTime, evtTime, actTime = 64'h0;
  int nErrors = 0, cmpCount = 0, fireCnt = 0, n;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (actFire === 1'b1) fireCnt <= fireCnt + 1;
  pse_time_slave DUT (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxValid(rxValid), .rxType(rxType), .rxDstIp(rxDstIp),
    .rxDstPort(rxDstPort), .rxTime(rxTime), .txValid(txValid), .txType(txType),
    .txDstIp(txDstIp), .txDstPort(txDstPort), .txTime(txTime), .actValid(actValid),
    .actTime(actTime), .actFire(actFire), .acqStartPulse(acqStartPulse),
    .frameStartPulse(frameStartPulse), .frameNumber(frameNumber), .evtValid(evtValid),
    .evtReady(evtReady), .evtId(evtId), .evtTime(evtTime), .evtFrame(evtFrame));
  pse_ptp_master ptpMaster (.sys_clk(sys_clk), .txValid(txValid), .rxValid(rxValid),
    .rxType(rxType), .rxDstIp(rxDstIp), .rxDstPort(rxDstPort), .rxTime(rxTime));
  // ==========================================================
  // Tasks
  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Three edges per transfer, so command spacing stays fixed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      nErrors++;
      end_sim();
    end else begin
      rdData = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({32'h0, rdData}, {32'h0, exp});
  endtask
  task automatic cap(input logic [63:0] exp);
    apb(1'b1, pse_pkg::REG_CMD, 32'h2);
    rd(pse_pkg::REG_CAP_LO, exp[31:0]);
    rd(pse_pkg::REG_CAP_HI, exp[63:32]);
  endtask
  task automatic pulse(input logic a, input logic f, input logic act);
    @(posedge sys_clk);
    acqStartPulse <= a;
    frameStartPulse <= f;
    actValid <= act;
    frameNumber <= 32'h55aa;
    @(posedge sys_clk);
    acqStartPulse <= 1'b0;
    frameStartPulse <= 1'b0;
    actValid <= 1'b0;
    // Frame number moves on, so a late capture would show
    frameNumber <= 32'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(pse_pkg::REG_FREQ_LO, 32'h3b9aca00);
    rd(pse_pkg::REG_FREQ_HI, 32'h0);
    rd(pse_pkg::REG_EVT_NOTIFY, 32'h0);
    rd(pse_pkg::REG_STATUS, 32'h0);
    rd(8'h38, 32'h0);
    chk({63'h0, errBit}, 64'h1);
    $display("test reset done");
    apb(1'b1, pse_pkg::REG_EVT_SEL, 32'h1);
    pulse(1'b0, 1'b1, 1'b1);
    chk({63'h0, evtValid}, 64'h0);
    chk(64'(fireCnt), 64'h0);
    apb(1'b1, pse_pkg::REG_EVT_SEL, 32'h0);
    apb(1'b1, pse_pkg::REG_EVT_NOTIFY, 32'h1);
    apb(1'b1, pse_pkg::REG_CMD, 32'h1);
    cap(64'hc8);
    cap(64'h44c);
    fork
      pulse(1'b1, 1'b0, 1'b0);
      begin
        n = 0;
        do begin
          @(posedge sys_clk);
          n++;
        end while (evtValid !== 1'b1 && n < 10);
        chk(64'(n), 64'h4);
      end
    join_any
    chk({48'h0, evtId}, 64'h9011);
    chk(evtTime, 64'h76c);
    chk({32'h0, evtFrame}, 64'h55aa);
    evtReady <= 1'b1;
    @(posedge sys_clk);
    evtReady <= 1'b0;
    wait fork;
    rd(pse_pkg::REG_ACQ_TIME_LO, 32'h76c);
    rd(pse_pkg::REG_ACQ_FRAME, 32'h55aa);
    $display("test events done");
    apb(1'b1, pse_pkg::REG_CTRL, 32'h1);
    rd(pse_pkg::REG_STATUS, 32'h1);
    ptpMaster.send(pse_pkg::MSG_ANNOUNCE, 80'h0, 1'b0);
    rd(pse_pkg::REG_STATUS, 32'h2);
    ptpMaster.send(pse_pkg::MSG_SYNC, 80'h0, 1'b1);
    rd(pse_pkg::REG_STATUS, 32'h2);
    ptpMaster.send(pse_pkg::MSG_SYNC, 80'h0, 1'b0);
    rd(pse_pkg::REG_STATUS, 32'h3);
    pulse(1'b0, 1'b0, 1'b1);
    chk(64'(fireCnt), 64'h1);
    ptpMaster.send(pse_pkg::MSG_FOLLOW_UP, 80'h1234ffffffffffffff00, 1'b0);
    #1;
    chk({63'h0, txValid}, 64'h1);
    chk({60'h0, txType}, 64'h1);
    chk({48'h0, txDstPort}, 64'h13f);
    chk({32'h0, txDstIp}, 64'he0000181);
    chk(txTime, 64'h16a8);
    cap(64'h7fffffffffffffc8);
    cap(64'h320);
    apb(1'b1, pse_pkg::REG_CMD, 32'h1);
    cap(64'h7d0);
    chk(64'(ptpMaster.delayReqs), 64'h1);
    $display("test sync done");
    end_sim();
  end
endmodule
